// ---- rtl/wms_map.svh ----
// Register map, field positions, reset values and speed scaling constant
// of the winder mode sequencer. Definitions only.
`ifndef WMS_MAP_SVH
`define WMS_MAP_SVH

// Register byte offsets
`define WMS_A_CFG 8'h00
`define WMS_A_JOG 8'h04
`define WMS_A_TGT 8'h08
`define WMS_A_STAT 8'h0C
`define WMS_A_LEN 8'h10
`define WMS_A_IRQ 8'h14
`define WMS_A_MASK 8'h18

// Configuration fields
`define WMS_F_PARK_PID 0
`define WMS_F_JOG_LINE 1
`define WMS_F_MEM_EN 2
`define WMS_F_BATCH_EN 3
`define WMS_F_BATCH_DIAM 4
`define WMS_F_SINK 5
`define WMS_F_POL_LO 8
`define WMS_F_POL_HI 13
`define WMS_CFG_RST 14'h0000
`define WMS_IO_MASK 14'h3F20

// Discrete input assignment
`define WMS_I_ENABLE 0
`define WMS_I_RUN 1
`define WMS_I_PARK 2
`define WMS_I_JOG 3
`define WMS_I_FAULT 4
`define WMS_I_BRESET 5

// Interrupt status bits
`define WMS_E_FAULT 0
`define WMS_E_DONE 1
`define WMS_E_REJ 2

// Status register fields
`define WMS_S_IN_LO 8
`define WMS_S_DONE 16
`define WMS_S_JOGOK 17

// Speed scaling: reciprocal diameter is unsigned 8.8 fixed point
`define WMS_RECIP_SH 8

`endif

// ---- rtl/wms_pkg.sv ----
// Types shared by the winder mode sequencer.
// Assumes wms_map.svh supplies the numeric constants.
package wms_pkg;
    typedef enum logic [2:0] {
        WMS_DISABLE,
        WMS_PARK,
        WMS_JOG,
        WMS_RUN,
        WMS_FAULT
    } wms_mode_t;
endpackage

// ---- rtl/wms_sequencer.sv ----
// Winder operating-mode sequencer with APB registers.
// Assumes an APB master on pclk and raw discrete pins from outside.
//
// Behaviour
// - Park mode outputs torque from roll diameter for light constant tension.
// - Park mode tension trim enabled or disabled by configuration bit.
// - Winder jog switches drive from torque to velocity regulation.
// - Constant-rotation jog commands fixed configured speed regardless of roll.
// - Constant-web-speed jog scales speed by reciprocal roll diameter.
// - Constant-web-speed jog only valid while diameter retention active; here retention is only mirrored to status, and line-speed jog runs regardless.
// - Run enables diameter calculation, tension trim, torque to drive.
// - Run takes precedence over park when both requested.
// - Fault input active enters fault mode, drops fault relay.
// - Batch length mode counts web wheel pulses against target.
// - Batch diameter mode winds until diameter reaches target.
// - Input/output configuration writes refused unless in disabled mode.
// - Default source logic: inputs rest low, active when driven high.
// - Sink logic: inputs rest high, active when pulled low.
// - Six per-input polarity bits, reset to closed contact means on.
// - Drive-run relay energized in run, jog or park modes only.
// - Fault relay energized normally, released only during fault.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "wms_map.svh"

module wms_sequencer #(
    parameter int NIN = 6,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Discrete pins and web length wheel
    input wire logic [NIN-1:0] din_pin,
    input wire logic wheel_pin,
    // Loop data from the diameter calculator and tension trim
    input wire logic [DW-1:0] diam,
    input wire logic [DW-1:0] recip_diam,
    input wire logic [DW-1:0] trim,
    // Drive side
    output logic [DW-1:0] drive_cmd,
    output logic torque_sel,
    output logic diam_calc_en,
    output logic trim_en,
    output logic relay_run,
    output logic relay_fault,
    output logic [2:0] mode_out,
    output logic irq
);
    // Six inputs are wired to modes; the 8.8 speed product needs DW >= 8
    if (NIN != 6 || DW < 8 || DW > 16) begin : g_bad_param
        $error("wms_sequencer: unsupported NIN or DW");
    end

    // ------------------------------------------------------------
    // Input synchroniser and conditioning
    // ------------------------------------------------------------
    logic [NIN:0] s1, s2, s3, stab;
    logic [13:0] cfg;
    logic [NIN-1:0] asserted, din_on;
    logic wheel_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= {wheel_pin, din_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change is accepted only when two stages agree
    genvar gi;
    generate
        for (gi = 0; gi <= NIN; gi++) begin : g_stab
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    stab[gi] <= 1'b0;
                else if (s2[gi] == s3[gi])
                    stab[gi] <= s3[gi];
            end
        end
        for (gi = 0; gi < NIN; gi++) begin : g_cond
            // Sink logic inverts the resting level
            assign asserted[gi] = stab[gi] ^ cfg[`WMS_F_SINK];
            // Polarity 1 selects open contact means on
            assign din_on[gi] = asserted[gi] ^ cfg[`WMS_F_POL_LO + gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    wms_pkg::wms_mode_t mode, next_mode;
    logic done;

    always_comb begin
        if (din_on[`WMS_I_FAULT])
            next_mode = wms_pkg::WMS_FAULT;
        else if (!din_on[`WMS_I_ENABLE])
            next_mode = wms_pkg::WMS_DISABLE;
        else if (din_on[`WMS_I_RUN] && !done)
            next_mode = wms_pkg::WMS_RUN;
        else if (din_on[`WMS_I_JOG])
            next_mode = wms_pkg::WMS_JOG;
        else if (din_on[`WMS_I_PARK])
            next_mode = wms_pkg::WMS_PARK;
        else
            next_mode = wms_pkg::WMS_DISABLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode <= wms_pkg::WMS_DISABLE;
        else
            mode <= next_mode;
    end

    // Relays follow next_mode so they change with the mode itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_run <= 1'b0;
            relay_fault <= 1'b1;
            mode_out <= 3'h0;
        end else begin
            relay_run <= next_mode == wms_pkg::WMS_RUN ||
                next_mode == wms_pkg::WMS_JOG ||
                next_mode == wms_pkg::WMS_PARK;
            relay_fault <= next_mode != wms_pkg::WMS_FAULT;
            mode_out <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Drive command
    // ------------------------------------------------------------
    logic [DW-1:0] jog_speed, target;
    logic [DW:0] sum;
    logic [2*DW-1:0] prod;
    logic use_trim;

    assign use_trim = next_mode == wms_pkg::WMS_RUN ||
        (next_mode == wms_pkg::WMS_PARK && cfg[`WMS_F_PARK_PID]);
    assign sum = {1'b0, diam} + {1'b0, (use_trim ? trim : '0)};
    assign prod = jog_speed * recip_diam;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_cmd <= '0;
            torque_sel <= 1'b1;
            diam_calc_en <= 1'b0;
            trim_en <= 1'b0;
        end else begin
            torque_sel <= next_mode != wms_pkg::WMS_JOG;
            diam_calc_en <= next_mode == wms_pkg::WMS_RUN;
            trim_en <= use_trim;
            case (next_mode)
                wms_pkg::WMS_RUN, wms_pkg::WMS_PARK:
                    // Saturate rather than wrap on overflow
                    drive_cmd <= sum[DW] ? '1 : sum[DW-1:0];
                wms_pkg::WMS_JOG:
                    if (cfg[`WMS_F_JOG_LINE])
                        drive_cmd <= prod[`WMS_RECIP_SH +: DW];
                    else
                        drive_cmd <= jog_speed;
                default:
                    drive_cmd <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Batch length and diameter
    // ------------------------------------------------------------
    logic [DW-1:0] len;
    logic hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wheel_q <= 1'b0;
        else
            wheel_q <= stab[NIN];
    end

    assign hit = cfg[`WMS_F_BATCH_DIAM] ? diam >= target
        : len >= target;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len <= '0;
            done <= 1'b0;
        end else if (din_on[`WMS_I_BRESET]) begin
            len <= '0;
            done <= 1'b0;
        end else begin
            if (cfg[`WMS_F_BATCH_EN] && !cfg[`WMS_F_BATCH_DIAM] &&
                mode == wms_pkg::WMS_RUN && stab[NIN] && !wheel_q &&
                len != '1)
                len <= len + 1'b1;
            if (cfg[`WMS_F_BATCH_EN] && mode == wms_pkg::WMS_RUN && hit)
                done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // APB registers and interrupts
    // ------------------------------------------------------------
    logic wr, rd_hit, cfg_wr, rej;
    logic [2:0] ists, imask, ev, next_ists, next_imask;
    logic [31:0] rdv;

    assign wr = psel && penable && pready && pwrite;
    assign cfg_wr = wr && paddr == `WMS_A_CFG;
    assign rej = cfg_wr && mode != wms_pkg::WMS_DISABLE &&
        ((pwdata[13:0] ^ cfg) & `WMS_IO_MASK) != 14'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `WMS_CFG_RST;
            jog_speed <= '0;
            target <= '0;
            imask <= 3'h0;
        end else if (wr) begin
            case (paddr)
                `WMS_A_CFG:
                    if (mode == wms_pkg::WMS_DISABLE)
                        cfg <= pwdata[13:0];
                    else
                        // Keep I/O fields while the drive may move
                        cfg <= (cfg & `WMS_IO_MASK) |
                            (pwdata[13:0] & ~`WMS_IO_MASK);
                `WMS_A_JOG: jog_speed <= pwdata[DW-1:0];
                `WMS_A_TGT: target <= pwdata[DW-1:0];
                `WMS_A_MASK: imask <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    assign ev[`WMS_E_FAULT] = next_mode == wms_pkg::WMS_FAULT &&
        mode != wms_pkg::WMS_FAULT;
    assign ev[`WMS_E_DONE] = hit && !done && cfg[`WMS_F_BATCH_EN] &&
        mode == wms_pkg::WMS_RUN && !din_on[`WMS_I_BRESET];
    assign ev[`WMS_E_REJ] = rej;
    // A new event wins over a write-one clear in the same cycle
    assign next_ists = ev |
        (ists & ~((wr && paddr == `WMS_A_IRQ) ? pwdata[2:0] : 3'h0));
    // A mask written now reaches irq together with the status it gates
    assign next_imask = (wr && paddr == `WMS_A_MASK) ? pwdata[2:0] : imask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists <= 3'h0;
            irq <= 1'b0;
        end else begin
            ists <= next_ists;
            irq <= |(next_ists & next_imask);
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rdv = 32'h0000_0000;
        case (paddr)
            `WMS_A_CFG: rdv[13:0] = cfg;
            `WMS_A_JOG: rdv[DW-1:0] = jog_speed;
            `WMS_A_TGT: rdv[DW-1:0] = target;
            `WMS_A_STAT: begin
                rdv[2:0] = mode;
                rdv[`WMS_S_IN_LO +: NIN] = din_on;
                rdv[`WMS_S_DONE] = done;
                // Line-speed jog only tracks when diameter is retained
                rdv[`WMS_S_JOGOK] = cfg[`WMS_F_MEM_EN];
            end
            `WMS_A_LEN: rdv[DW-1:0] = len;
            `WMS_A_IRQ: rdv[2:0] = ists;
            `WMS_A_MASK: rdv[2:0] = imask;
            default: rd_hit = 1'b0;
        endcase
    end

    // Answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !rd_hit;
            if (psel && penable && !pready && !pwrite)
                prdata <= rdv;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fault_entry_a: assert property (
        din_on[`WMS_I_FAULT] |=> mode == wms_pkg::WMS_FAULT && !relay_fault)
        else $error("fault input did not force fault mode");
    fault_inhibit_a: assert property (
        mode == wms_pkg::WMS_FAULT |-> drive_cmd == '0)
        else $error("drive command not inhibited in fault");
    run_over_park_a: assert property (
        din_on[`WMS_I_ENABLE] && !din_on[`WMS_I_FAULT] && !done &&
        din_on[`WMS_I_RUN] && din_on[`WMS_I_PARK]
        |=> mode == wms_pkg::WMS_RUN)
        else $error("run lost to park");
    jog_velocity_a: assert property (
        mode == wms_pkg::WMS_JOG |-> !torque_sel)
        else $error("jog not in velocity control");
    jog_rpm_a: assert property (
        next_mode == wms_pkg::WMS_JOG && !cfg[`WMS_F_JOG_LINE]
        |=> drive_cmd == $past(jog_speed))
        else $error("constant rotation jog speed wrong");
    run_enables_a: assert property (
        mode == wms_pkg::WMS_RUN |-> diam_calc_en && trim_en && torque_sel)
        else $error("run did not enable loops");
    park_trim_a: assert property (
        mode == wms_pkg::WMS_PARK |-> trim_en == $past(cfg[`WMS_F_PARK_PID]))
        else $error("park trim setting not followed");
    run_relay_a: assert property (
        relay_run == (mode == wms_pkg::WMS_RUN ||
        mode == wms_pkg::WMS_JOG || mode == wms_pkg::WMS_PARK))
        else $error("run relay disagrees with mode");
    io_guard_a: assert property (
        mode != wms_pkg::WMS_DISABLE |=>
        (cfg & `WMS_IO_MASK) == ($past(cfg) & `WMS_IO_MASK))
        else $error("I/O setting changed outside disabled mode");
    relay_fault_a: assert property (
        mode != wms_pkg::WMS_FAULT |-> relay_fault)
        else $error("fault relay released without fault");
    batch_len_a: assert property (
        $rose(done) && !cfg[`WMS_F_BATCH_DIAM] |-> $past(len >= target))
        else $error("batch length ended early");
    batch_diam_a: assert property (
        $rose(done) && cfg[`WMS_F_BATCH_DIAM] |-> $past(diam >= target))
        else $error("batch diameter ended early");
    jog_line_a: assert property (
        next_mode == wms_pkg::WMS_JOG && cfg[`WMS_F_JOG_LINE]
        |=> drive_cmd == $past(prod[`WMS_RECIP_SH +: DW]))
        else $error("line speed jog command wrong");
    fault_event_a: assert property (
        $rose(mode == wms_pkg::WMS_FAULT) |-> ists[`WMS_E_FAULT])
        else $error("fault entry not flagged");
    // Per bit: no accepted change while its last two stages disagreed
    input_filter_a: assert property (
        ((stab ^ $past(stab)) & $past(s2 ^ s3)) == '0)
        else $error("input accepted before stages agreed");
    irq_level_a: assert property (
        irq == |(ists & imask))
        else $error("interrupt level disagrees with status");
    park_diam_a: assert property (
        next_mode == wms_pkg::WMS_PARK && !cfg[`WMS_F_PARK_PID]
        |=> drive_cmd == $past(diam))
        else $error("park torque not diameter based");
    park_torque_a: assert property (
        mode == wms_pkg::WMS_PARK |-> torque_sel && relay_run)
        else $error("park not in torque control");
endmodule // wms_sequencer

// ---- verif/tb_winder_mode_sequencer.sv ----
// Self-checking bench for the winder mode sequencer.
// Assumes the far-side model drives the pins; APB reads checked by monitor.
`timescale 1ns/10ps
`include "wms_map.svh"

module tb_winder_mode_sequencer;
    typedef struct {logic [31:0] d; logic e; logic rd;} wms_note_t;
    localparam logic [5:0] k_en = 6'h01, k_rn = 6'h02, k_pk = 6'h04;
    localparam logic [5:0] k_jg = 6'h08, k_ft = 6'h10, k_br = 6'h20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] din_pin, req;
    logic wheel_pin, wheel_req, torque_sel, diam_calc_en, trim_en;
    logic relay_run, relay_fault;
    logic [15:0] diam, recip_diam, trim, drive_cmd, jogv;
    logic [2:0] mode_out;
    logic [13:0] cfg;
    int err_count, comparisons;
    wms_note_t q[$];
    wms_note_t n;

    wms_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din_pin(din_pin), .wheel_pin(wheel_pin), .diam(diam),
        .recip_diam(recip_diam), .trim(trim), .drive_cmd(drive_cmd),
        .torque_sel(torque_sel), .diam_calc_en(diam_calc_en),
        .trim_en(trim_en), .relay_run(relay_run), .relay_fault(relay_fault),
        .mode_out(mode_out), .irq(irq));
    wms_far_model far (.pclk(pclk), .req(req), .sink(cfg[`WMS_F_SINK]),
        .pol(cfg[13:8]), .wheel_req(wheel_req), .din_pin(din_pin),
        .wheel_pin(wheel_pin));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask

    // ----------------------------------------------------------------
    // APB master and read monitor
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] ed,
                       input logic ee);
        q.push_back('{ed, ee, !w});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            n = q.pop_front();
            chk("pslverr", n.e, pslverr);
            if (n.rd) begin
                chk("prdata", n.d, prdata);
            end
        end
    end

    // Pin changes need the synchroniser plus one edge to reach outputs
    task automatic settle();
        repeat (8) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic set_req(input logic [5:0] v);
        @(posedge pclk);
        req <= v;
        settle();
    endtask

    task automatic look(input logic [2:0] m, input logic [3:0] f,
                        input logic [15:0] c);
        chk("mode_out", m, mode_out);
        chk("flags", f, {diam_calc_en, trim_en, relay_run, relay_fault});
        chk("drive_cmd", c, drive_cmd);
    endtask

    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge pclk);
            wheel_req <= 1'b1;
            repeat (6) @(posedge pclk);
            wheel_req <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        settle();
    endtask

    function automatic logic [31:0] stat(input logic [2:0] m,
                                         input logic dn);
        return {14'h0, cfg[2], dn, 2'b00, req, 5'h00, m};
    endfunction

    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        {presetn, psel, penable, pwrite, wheel_req} = 5'b0;
        {paddr, pwdata, req, cfg, jogv} = '0;
        {diam, recip_diam, trim} = '0;
        err_count = 0;
        comparisons = 0;
        void'($urandom(32'hCA7C));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        diam <= 16'($urandom) & 16'h3FFF;
        trim <= 16'($urandom) & 16'h3FFF;
        recip_diam <= 16'($urandom);
        jogv = 16'($urandom) & 16'h00FF;
        @(negedge pclk);
        look(wms_pkg::WMS_DISABLE, 4'b0001, 16'h0);
        chk("din_pin", 6'h00, din_pin);
        rd(`WMS_A_CFG, 32'h0);
        wr(`WMS_A_MASK, 32'h7);
        set_req(k_en | k_pk);
        look(wms_pkg::WMS_PARK, 4'b0011, diam);
        chk("torque_sel", 1'b1, torque_sel);
        rd(`WMS_A_STAT, stat(wms_pkg::WMS_PARK, 1'b0));
        cfg = 14'h0001;
        wr(`WMS_A_CFG, 32'h1);
        settle();
        look(wms_pkg::WMS_PARK, 4'b0111, 16'(diam + trim));
        set_req(k_en | k_rn | k_pk);
        look(wms_pkg::WMS_RUN, 4'b1111, 16'(diam + trim));
        // I/O fields must survive a write outside disabled mode
        wr(`WMS_A_CFG, 32'h3F21);
        settle();
        chk("irq", 1'b1, irq);
        rd(`WMS_A_CFG, 32'h1);
        rd(`WMS_A_IRQ, 32'h4);
        wr(`WMS_A_IRQ, 32'h4);
        wr(`WMS_A_JOG, {16'h0, jogv});
        set_req(k_en | k_jg);
        look(wms_pkg::WMS_JOG, 4'b0011, jogv);
        chk("torque_sel", 1'b0, torque_sel);
        cfg = 14'h0007;
        wr(`WMS_A_CFG, 32'h7);
        settle();
        r = (32'(jogv) * 32'(recip_diam)) >> `WMS_RECIP_SH;
        look(wms_pkg::WMS_JOG, 4'b0011, r[15:0]);
        rd(`WMS_A_STAT, stat(wms_pkg::WMS_JOG, 1'b0));
        set_req(k_en | k_rn | k_ft);
        look(wms_pkg::WMS_FAULT, 4'b0000, 16'h0);
        chk("irq", 1'b1, irq);
        rd(`WMS_A_IRQ, 32'h1);
        wr(`WMS_A_IRQ, 32'h1);
        set_req(k_en);
        look(wms_pkg::WMS_DISABLE, 4'b0001, 16'h0);
        chk("irq", 1'b0, irq);
        // Sink logic, then random polarity, both while disabled
        cfg = cfg | 14'h0020;
        wr(`WMS_A_CFG, {18'h0, cfg});
        settle();
        chk("din_pin", 6'h3E, din_pin);
        r = $urandom;
        cfg = (cfg & 14'h00FF) | (r[13:0] & 14'h3F00);
        wr(`WMS_A_CFG, {18'h0, cfg});
        rd(`WMS_A_CFG, {18'h0, cfg});
        set_req(k_en | k_pk);
        wr(`WMS_A_IRQ, 32'h7);
        look(wms_pkg::WMS_PARK, 4'b0111, 16'(diam + trim));
        rd(`WMS_A_STAT, stat(wms_pkg::WMS_PARK, 1'b0));
        // Full-scale diameter plus trim must clip, not wrap
        @(posedge pclk);
        diam <= 16'hFFFF;
        settle();
        chk("drive_cmd", 16'hFFFF, drive_cmd);
        // Batch by length, then by diameter
        set_req(k_en);
        wr(`WMS_A_TGT, 32'h3);
        cfg = cfg | 14'h0008;
        wr(`WMS_A_CFG, {18'h0, cfg});
        set_req(k_en | k_rn);
        pulse(2);
        rd(`WMS_A_LEN, 32'h2);
        chk("mode_out", wms_pkg::WMS_RUN, mode_out);
        pulse(1);
        look(wms_pkg::WMS_DISABLE, 4'b0001, 16'h0);
        rd(`WMS_A_STAT, stat(wms_pkg::WMS_DISABLE, 1'b1));
        chk("irq", 1'b1, irq);
        set_req(k_en | k_br);
        set_req(k_en);
        rd(`WMS_A_LEN, 32'h0);
        cfg = cfg | 14'h0010;
        wr(`WMS_A_CFG, {18'h0, cfg});
        wr(`WMS_A_TGT, 32'h2000);
        @(posedge pclk);
        diam <= 16'h1FFF;
        set_req(k_en | k_rn);
        chk("mode_out", wms_pkg::WMS_RUN, mode_out);
        @(posedge pclk);
        diam <= 16'h2000;
        settle();
        chk("mode_out", wms_pkg::WMS_DISABLE, mode_out);
        apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h1C, 32'hFFFF, 32'h0, 1'b1);
        // Let the monitor take the last answer before the verdict
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end
endmodule // tb_winder_mode_sequencer

// ---- verif/wms_far_model.sv ----
// Far-side model: switches on the discrete pins and the web wheel.
// Assumes the bench mirrors the logic type and polarity it programmed.
`timescale 1ns/10ps

module wms_far_model (
    // Clock
    input wire logic pclk,
    // Requests and mirrored settings from the bench
    input wire logic [5:0] req,
    input wire logic sink,
    input wire logic [5:0] pol,
    input wire logic wheel_req,
    // Pins
    output logic [5:0] din_pin,
    output logic wheel_pin
);
    initial begin
        din_pin = 6'h00;
        wheel_pin = 1'b0;
    end

    // Idle pins rest at the sink level flipped by pol, an active one at the other level
    always @(posedge pclk) begin
        din_pin <= req ^ pol ^ {6{sink}};
        wheel_pin <= wheel_req;
    end
endmodule // wms_far_model
